// File: src/sdtc_pkg.sv
// constants, field positions and encodings of the secondary display timing
package sdtc_pkg;

	localparam int APB_AW = 20;
	localparam int NREG   = 11;
	localparam int FW     = 128;
	localparam int FETCH_BYTES = 16;

	localparam logic [19:0] OFF_CTRL  = 20'h8_0200;
	localparam logic [19:0] OFF_FB    = 20'h8_0204;
	localparam logic [19:0] OFF_STR   = 20'h8_0208;
	localparam logic [19:0] OFF_HTOT  = 20'h8_020C;
	localparam logic [19:0] OFF_HSYNC = 20'h8_0210;
	localparam logic [19:0] OFF_VTOT  = 20'h8_0214;
	localparam logic [19:0] OFF_VSYNC = 20'h8_0218;
	localparam logic [19:0] OFF_SIG   = 20'h8_021C;
	localparam logic [19:0] OFF_LINE  = 20'h8_0220;
	localparam logic [19:0] OFF_MON   = 20'h8_0224;
	localparam logic [19:0] OFF_SCALE = 20'h8_0228;

	localparam int IDX_CTRL  = (OFF_CTRL  - OFF_CTRL) / 4;
	localparam int IDX_FB    = (OFF_FB    - OFF_CTRL) / 4;
	localparam int IDX_STR   = (OFF_STR   - OFF_CTRL) / 4;
	localparam int IDX_HTOT  = (OFF_HTOT  - OFF_CTRL) / 4;
	localparam int IDX_HSYNC = (OFF_HSYNC - OFF_CTRL) / 4;
	localparam int IDX_VTOT  = (OFF_VTOT  - OFF_CTRL) / 4;
	localparam int IDX_VSYNC = (OFF_VSYNC - OFF_CTRL) / 4;
	localparam int IDX_SIG   = (OFF_SIG   - OFF_CTRL) / 4;
	localparam int IDX_LINE  = (OFF_LINE  - OFF_CTRL) / 4;
	localparam int IDX_MON   = (OFF_MON   - OFF_CTRL) / 4;
	localparam int IDX_SCALE = (OFF_SCALE - OFF_CTRL) / 4;

	// writable bits per register; everything else reads as zero or status
	localparam logic [31:0] WM_CTRL  = 32'h05FF_75FF;
	localparam logic [31:0] WM_FB    = 32'h0BFF_FFF0;
	localparam logic [31:0] WM_STR   = 32'h3FF0_3FF0;
	localparam logic [31:0] WM_HTOT  = 32'h0FFF_0FFF;
	localparam logic [31:0] WM_HSYNC = 32'h00FF_0FFF;
	localparam logic [31:0] WM_VTOT  = 32'h07FF_07FF;
	localparam logic [31:0] WM_VSYNC = 32'h003F_07FF;
	localparam logic [31:0] WM_SIG   = 32'h0000_000F;
	localparam logic [31:0] WM_MON   = 32'h05FF_FFFF;
	localparam logic [31:0] WM_SCALE = 32'h0FFF_0FFF;
	localparam logic [31:0] REG_RST  = 32'h0000_0000;

	localparam int CTRL_FMT_LSB   = 0;
	localparam int CTRL_PLANE     = 2;
	localparam int CTRL_GAMMA     = 3;
	localparam int CTRL_PAN_LSB   = 4;
	localparam int CTRL_RUN       = 8;
	localparam int CTRL_BLANK     = 10;
	localparam int CTRL_FSTAT     = 11;
	localparam int CTRL_LPOL      = 12;
	localparam int CTRL_FPOL      = 13;
	localparam int CTRL_CKPOL     = 14;
	localparam int CTRL_LVL_LSB   = 16;
	localparam int CTRL_SEL_LSB   = 18;
	localparam int CTRL_FE_LSB    = 20;
	localparam int CTRL_WIDEN_OFF = 26;
	localparam int FB_EXT         = 27;
	localparam int FB_FLIP        = 31;
	localparam int STR_WIN_LSB    = 20;
	localparam int STR_OFS_LSB    = 4;
	localparam int UPPER_LSB      = 16;
	localparam int SIG_EN         = 3;
	localparam int SIG_CLR        = 2;
	localparam int SIG_OUT_LSB    = 16;
	localparam int MON_EN0        = 24;
	localparam int MON_DET0       = 25;
	localparam int MON_EN1        = 26;
	localparam int MON_DET1       = 27;

	localparam logic [15:0] SIG_POLY = 16'h1021;

	typedef enum logic [1:0] {FMT_IDX8, FMT_RGB565, FMT_RGB888, FMT_RSVD}
		sdtc_fmt_t;
	typedef enum logic [1:0] {SRC_PANEL, SRC_VGA, SRC_CRT, SRC_RSVD}
		sdtc_src_t;
	typedef enum logic [1:0] {SIG_RED, SIG_GREEN, SIG_BLUE, SIG_NONE}
		sdtc_sigsel_t;

endpackage

// File: src/sdtc_sync2.sv
// two-flop synchroniser for levels from outside the pclk domain
`timescale 1ns/100ps
module sdtc_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// level in and out
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sdtc_sy_t;

	sdtc_sy_t s_q;
	sdtc_sy_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.meta = async_i;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_o = s_q.sync;
endmodule

// File: src/sdtc_sig.sv
// 16-bit signature register over one output color component
`timescale 1ns/100ps
module sdtc_sig (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// control
	input  wire logic        en_i,
	input  wire logic        clr_i,
	input  wire logic [1:0]  sel_i,
	input  wire logic        tick_i,
	input  wire logic [23:0] rgb_i,
	// result
	output logic      [15:0] sig_o
);
	import sdtc_pkg::*;

	typedef struct packed {
		logic [15:0] sig;
	} sdtc_sg_t;

	sdtc_sg_t   s_q;
	sdtc_sg_t   s_d;
	logic [7:0] comp;

	always_comb begin
		s_d  = s_q;
		comp = 8'h00;
		unique case (sdtc_sigsel_t'(sel_i))
			SIG_RED:   comp = rgb_i[23:16];
			SIG_GREEN: comp = rgb_i[15:8];
			SIG_BLUE:  comp = rgb_i[7:0];
			SIG_NONE:  comp = 8'h00;
		endcase
		if (clr_i) begin
			s_d.sig = 16'h0000;
		end else if (en_i && tick_i) begin
			s_d.sig = {s_q.sig[14:0], 1'b0} ^ {8'h00, comp}
				^ (s_q.sig[15] ? SIG_POLY : 16'h0000);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sig_o = s_q.sig;
endmodule

// File: src/sdtc_top.sv
// secondary display timing, plane fetch and register file
// Operation
// - plane enable change is applied only at the next vertical sync
// - format 00 indexed 8-bit, 01 RGB 5:6:5, 10 RGB 8:8:8, 11 reserved
// - gamma only active with enable bit 3 and a 5:6:5 or 8:8:8 plane
// - fetch request once empty entries reach 1, 3, 7 or 11 per code
// - output source: 00 panel, 01 VGA, 10 CRT plane, 11 reserved
// - bits 12/13/14 invert line sync, frame sync and CRT clock
// - control bit 11 reads current frame sync state, writes ignored
// - control bit 10 blanks the display output
// - timing generator runs only while control bit 8 is set
// - bits 7:4 give first pixel within first fetched unit
// - VGA 6-bit colors widened to 8 bits unless bit 26 set
// - bits 24..20 enable centering, lock, expansion, interpolations
// - base in 25:4, low bits zero, bit 27 memory select, 31 flip
// - window width and stride counted in 16-byte units
// - line total and active end are pixel counts minus one
// - line sync starts at programmed pixel plus one, width pixels
// - frame total and active end are line counts minus one
// - frame sync starts at programmed line plus one, 6-bit height
// - signature enable bit 3, reset bit 2, color select, reads 31:16
// - current fetch line reads back in bits 10:0
// - monitor sense drives test color on enabled channels, reports 25/27
`timescale 1ns/100ps
module sdtc_top #(
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [sdtc_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// pixel clock from the display side
	input  wire logic                        pix_clk_i,
	// video out
	output logic                             hsync_o,
	output logic                             vsync_o,
	output logic                             crt_clk_o,
	output logic                             blank_o,
	output logic      [23:0]                 rgb_o,
	output logic                             gamma_on_o,
	output logic      [4:0]                  feature_en_o,
	output logic      [23:0]                 scale_o,
	// other pixel sources
	input  wire logic [23:0]                 panel_rgb_i,
	input  wire logic [17:0]                 vga_rgb_i,
	// frame buffer read port
	output logic                             mem_req_o,
	output logic      [25:0]                 mem_addr_o,
	output logic                             mem_ext_o,
	input  wire logic                        mem_gnt_i,
	input  wire logic                        mem_rvalid_i,
	input  wire logic [sdtc_pkg::FW-1:0]     mem_rdata_i,
	// monitor sense
	output logic      [1:0]                  sense_en_o,
	input  wire logic [1:0]                  sense_i
);
	import sdtc_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [NREG-1:0][31:0]  regs;
		logic                   plane_on;
		logic [25:0]            base_act;
		logic                   flip;
		logic                   pclk_d;
		logic [11:0]            hcnt;
		logic [10:0]            vcnt;
		logic                   lsync;
		logic                   fsync;
		logic                   de;
		logic [DEPTH-1:0][FW-1:0] fifo;
		logic [PW-1:0]          wp;
		logic [PW-1:0]          rp;
		logic [CW-1:0]          fill;
		logic [CW-1:0]          pend;
		logic [CW-1:0]          drop;
		logic [9:0]             units;
		logic [25:0]            addr;
		logic                   req;
		logic [3:0]             pix;
		logic [23:0]            rgb;
		logic                   lsync_o;
		logic                   fsync_o;
		logic                   gamma;
		logic                   clk_o;
		logic                   blank;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
	} sdtc_st_t;

	sdtc_st_t    s_q;
	sdtc_st_t    s_d;
	logic        pclk_sync;
	logic [1:0]  sense_sync;
	logic [15:0] sig_val;
	logic [31:0] ctrl;
	logic        run;
	logic        tick;
	logic        hit;
	logic [3:0]  aidx;

	function automatic logic [31:0] wmask(input logic [3:0] i);
		logic [31:0] m;
		m = 32'h0000_0000;
		case (int'(i))
			IDX_CTRL:  m = WM_CTRL;
			IDX_FB:    m = WM_FB;
			IDX_STR:   m = WM_STR;
			IDX_HTOT:  m = WM_HTOT;
			IDX_HSYNC: m = WM_HSYNC;
			IDX_VTOT:  m = WM_VTOT;
			IDX_VSYNC: m = WM_VSYNC;
			IDX_SIG:   m = WM_SIG;
			IDX_MON:   m = WM_MON;
			IDX_SCALE: m = WM_SCALE;
			default:   m = 32'h0000_0000;
		endcase
		return m;
	endfunction

	// sync window: start at programmed value plus one, width counts
	function automatic logic in_win(input logic [11:0] cnt,
			input logic [11:0] start, input logic [7:0] width);
		logic [13:0] a;
		logic [13:0] e;
		a = 14'(start) + 14'd1;
		e = a + 14'(width);
		return (14'(cnt) >= a) && (14'(cnt) < e);
	endfunction

	function automatic logic [3:0] last_pix(input logic [1:0] fmt);
		logic [3:0] r;
		r = 4'h0;
		unique case (sdtc_fmt_t'(fmt))
			FMT_IDX8:   r = 4'hF;
			FMT_RGB565: r = 4'h7;
			FMT_RGB888: r = 4'h3;
			FMT_RSVD:   r = 4'h0;
		endcase
		return r;
	endfunction

	function automatic logic [23:0] pix_of(input logic [FW-1:0] w,
			input logic [1:0] fmt, input logic [3:0] i);
		logic [7:0]  b;
		logic [15:0] h;
		logic [31:0] x;
		logic [23:0] r;
		b = w[{i, 3'b000} +: 8];
		h = w[{i[2:0], 4'h0} +: 16];
		x = w[{i[1:0], 5'h00} +: 32];
		r = 24'h00_0000;
		unique case (sdtc_fmt_t'(fmt))
			FMT_IDX8:   r = {b, b, b};
			FMT_RGB565: r = {h[15:11], h[15:13], h[10:5], h[10:9],
				h[4:0], h[4:2]};
			FMT_RGB888: r = x[23:0];
			FMT_RSVD:   r = 24'h00_0000;
		endcase
		return r;
	endfunction

	// pixel clock comes from another domain: sample it twice first
	sdtc_sync2 #(.W(1)) u_pclk_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_i (pix_clk_i),
		.sync_o  (pclk_sync)
	);

	sdtc_sync2 #(.W(2)) u_sense_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_i (sense_i),
		.sync_o  (sense_sync)
	);

	sdtc_sig u_sig (
		.pclk    (pclk),
		.presetn (presetn),
		.en_i    (s_q.regs[IDX_SIG][SIG_EN]),
		.clr_i   (s_q.regs[IDX_SIG][SIG_CLR]),
		.sel_i   (s_q.regs[IDX_SIG][1:0]),
		.tick_i  (tick && s_q.de),
		.rgb_i   (s_q.rgb),
		.sig_o   (sig_val)
	);

	assign ctrl = s_q.regs[IDX_CTRL];
	assign run  = ctrl[CTRL_RUN];
	assign tick = pclk_sync && !s_q.pclk_d;
	assign aidx = paddr[5:2];
	assign hit  = (paddr[APB_AW-1:6] == OFF_CTRL[APB_AW-1:6])
		&& (int'(aidx) < NREG) && (paddr[1:0] == 2'b00);

	always_comb begin
		logic [31:0]   rd;
		logic [11:0]   hlast;
		logic [10:0]   vlast;
		logic          line_end;
		logic          fs_rise;
		logic          push;
		logic          pop;
		logic          gnt;
		logic [CW:0]   empty;
		logic [4:0]    need;
		logic [23:0]   px;
		logic [23:0]   plane_px;
		logic [13:0]   stride_b;
		rd       = 32'h0000_0000;
		hlast    = s_q.regs[IDX_HTOT][UPPER_LSB +: 12];
		vlast    = s_q.regs[IDX_VTOT][UPPER_LSB +: 11];
		line_end = 1'b0;
		fs_rise  = 1'b0;
		empty    = '0;
		push     = 1'b0;
		pop      = 1'b0;
		gnt      = s_q.req && mem_gnt_i;
		px       = 24'h00_0000;
		plane_px = 24'h00_0000;
		stride_b = {s_q.regs[IDX_STR][STR_OFS_LSB +: 10], 4'h0};
		need     = 5'd1;
		s_d      = s_q;
		s_d.pclk_d = pclk_sync;
		s_d.pready = 1'b1;

		// register reads are captured in the setup phase
		if (hit) begin
			rd = s_q.regs[aidx];
			case (int'(aidx))
				IDX_CTRL: rd[CTRL_FSTAT] = s_q.fsync;
				IDX_FB:   rd[FB_FLIP] = s_q.flip;
				IDX_SIG:  rd[SIG_OUT_LSB +: 16] = sig_val;
				IDX_LINE: rd = {21'h00_0000, s_q.vcnt};
				IDX_MON: begin
					rd[MON_DET0] = sense_sync[0] && s_q.regs[IDX_MON][MON_EN0];
					rd[MON_DET1] = sense_sync[1] && s_q.regs[IDX_MON][MON_EN1];
				end
				default: rd = s_q.regs[aidx];
			endcase
		end
		if (psel && !penable) begin
			s_d.prdata  = rd;
			s_d.pslverr = !hit;
		end

		// counters stop and clear while timing is disabled
		if (!run) begin
			s_d.hcnt = 12'h000;
			s_d.vcnt = 11'h000;
		end else if (tick) begin
			if (s_q.hcnt == hlast) begin
				line_end = 1'b1;
				s_d.hcnt = 12'h000;
				s_d.vcnt = (s_q.vcnt == vlast) ? 11'h000 : s_q.vcnt + 11'd1;
			end else begin
				s_d.hcnt = s_q.hcnt + 12'd1;
			end
		end
		s_d.lsync = run && in_win(s_d.hcnt, s_q.regs[IDX_HSYNC][11:0],
			s_q.regs[IDX_HSYNC][UPPER_LSB +: 8]);
		s_d.fsync = run && in_win({1'b0, s_d.vcnt},
			{1'b0, s_q.regs[IDX_VSYNC][10:0]},
			{2'b00, s_q.regs[IDX_VSYNC][UPPER_LSB +: 6]});
		// active end is last visible pixel and line
		s_d.de = run && (s_d.hcnt <= s_q.regs[IDX_HTOT][11:0])
			&& (s_d.vcnt <= s_q.regs[IDX_VTOT][10:0]);
		fs_rise = s_d.fsync && !s_q.fsync;

		// plane enable and new base take effect at frame sync
		if (fs_rise) begin
			s_d.plane_on = ctrl[CTRL_PLANE];
			s_d.base_act = {s_q.regs[IDX_FB][25:4], 4'h0};
			s_d.flip     = 1'b0;
		end
		// a base write pends a flip; the set beats the clear
		if (hit && psel && penable && pwrite && s_q.pready) begin
			s_d.regs[aidx] = pwdata & wmask(aidx);
			if (int'(aidx) == IDX_FB) begin
				s_d.flip = 1'b1;
			end
		end

		s_d.gamma = s_d.regs[IDX_CTRL][CTRL_GAMMA]
			&& (s_d.regs[IDX_CTRL][1:0] == FMT_RGB565
			|| s_d.regs[IDX_CTRL][1:0] == FMT_RGB888);

		unique case (ctrl[CTRL_LVL_LSB +: 2])
			2'b00: need = 5'd1;
			2'b01: need = 5'd3;
			2'b10: need = 5'd7;
			2'b11: need = 5'd11;
		endcase
		empty = (CW+1)'(DEPTH) - (CW+1)'(s_q.fill) - (CW+1)'(s_q.pend);
		if (gnt) begin
			s_d.req   = 1'b0;
			s_d.addr  = s_q.addr + 26'(FETCH_BYTES);
			s_d.units = s_q.units - 10'd1;
		end else if (!s_q.req && s_q.units != 10'h000 && s_q.plane_on
				&& run && empty >= (CW+1)'(need)) begin
			// ask for one unit when enough room
			s_d.req = 1'b1;
		end
		// words for a flushed line are discarded as they arrive
		if (mem_rvalid_i) begin
			if (s_q.drop != '0) begin
				s_d.drop = s_q.drop - CW'(1);
			end else if (int'(s_q.fill) < DEPTH) begin
				push = 1'b1;
				s_d.fifo[s_q.wp] = mem_rdata_i;
				s_d.wp = s_q.wp + PW'(1);
			end
		end
		s_d.pend = s_q.pend + CW'(gnt) - CW'(mem_rvalid_i && s_q.pend != '0);

		if (s_q.plane_on && s_q.fill != '0) begin
			plane_px = pix_of(s_q.fifo[s_q.rp], ctrl[1:0], s_q.pix);
		end
		if (tick && s_q.de && s_q.plane_on && s_q.fill != '0) begin
			pop = 1'b1;
			if (s_q.pix == last_pix(ctrl[1:0])) begin
				s_d.pix = 4'h0;
				s_d.rp  = s_q.rp + PW'(1);
			end else begin
				s_d.pix = s_q.pix + 4'd1;
			end
		end
		s_d.fill = s_q.fill + CW'(push)
			- CW'(pop && s_q.pix == last_pix(ctrl[1:0]));

		// next line: flush, reload fetch pointer and count
		if (line_end) begin
			s_d.req  = 1'b0;
			s_d.fill = '0;
			s_d.wp   = '0;
			s_d.rp   = '0;
			s_d.drop = s_d.pend;
			s_d.pix  = ctrl[CTRL_PAN_LSB +: 4] & last_pix(ctrl[1:0]);
			// window and stride in 16-byte units
			s_d.units = (s_d.vcnt <= s_q.regs[IDX_VTOT][10:0])
				? s_q.regs[IDX_STR][STR_WIN_LSB +: 10] : 10'h000;
			s_d.addr = s_q.base_act
				+ 26'(26'(s_d.vcnt) * 26'(stride_b));
		end

		unique case (sdtc_src_t'(ctrl[CTRL_SEL_LSB +: 2]))
			SRC_PANEL: px = panel_rgb_i;
			// widen 6-bit VGA color unless disabled
			SRC_VGA: px = ctrl[CTRL_WIDEN_OFF]
				? {2'b00, vga_rgb_i[17:12], 2'b00, vga_rgb_i[11:6],
					2'b00, vga_rgb_i[5:0]}
				: {vga_rgb_i[17:12], 2'b00, vga_rgb_i[11:6], 2'b00,
					vga_rgb_i[5:0], 2'b00};
			SRC_CRT:  px = plane_px;
			SRC_RSVD: px = 24'h00_0000;
		endcase
		if (!s_q.de || ctrl[CTRL_BLANK]) begin
			px = 24'h00_0000;
		end
		// sense test color overrides the picture
		if (s_q.regs[IDX_MON][MON_EN0] || s_q.regs[IDX_MON][MON_EN1]) begin
			px = s_q.regs[IDX_MON][23:0];
		end
		if (tick) begin
			s_d.rgb   = px;
			s_d.blank = !s_q.de || ctrl[CTRL_BLANK];
		end
		s_d.lsync_o = s_q.lsync ^ ctrl[CTRL_LPOL];
		s_d.fsync_o = s_q.fsync ^ ctrl[CTRL_FPOL];
		s_d.clk_o   = pclk_sync ^ ctrl[CTRL_CKPOL];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata     = s_q.prdata;
	assign pready     = s_q.pready;
	assign pslverr    = s_q.pslverr;
	assign hsync_o    = s_q.lsync_o;
	assign vsync_o    = s_q.fsync_o;
	assign crt_clk_o  = s_q.clk_o;
	assign blank_o    = s_q.blank;
	assign rgb_o      = s_q.rgb;
	assign gamma_on_o = s_q.gamma;
	// feature enables straight from the register
	assign feature_en_o = ctrl[CTRL_FE_LSB +: 5];
	assign scale_o    = {s_q.regs[IDX_SCALE][27:16], s_q.regs[IDX_SCALE][11:0]};
	assign mem_req_o  = s_q.req;
	assign mem_addr_o = s_q.addr;
	assign mem_ext_o  = s_q.regs[IDX_FB][FB_EXT];
	assign sense_en_o = {s_q.regs[IDX_MON][MON_EN1], s_q.regs[IDX_MON][MON_EN0]};
endmodule

// File: test/sdtc_mem_model.sv
// frame buffer read responder on the fetch side of the block
`timescale 1ns/100ps
module sdtc_mem_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// read port
	input  wire logic        req,
	input  wire logic [25:0] addr,
	output logic             gnt,
	output logic             rvalid,
	output logic [127:0]     rdata
);
	logic [25:0] pend [$];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gnt <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			pend.delete();
		end else begin
			// random stalls so the fifo level really matters
			gnt <= req && !gnt && ($urandom % 4 != 0);
			if (req && gnt)
				pend.push_back(addr);
			if (pend.size() > 0 && $urandom % 2) begin
				rvalid <= 1'b1;
				rdata <= {4{6'h00, pend.pop_front()}};
			end else begin
				// idle data toggles, never a stale copy
				rvalid <= 1'b0;
				rdata <= ~rdata;
			end
		end
	end
endmodule

// File: test/sdtc_top_properties.sv
// port checks of the display timing block
`timescale 1ns/100ps
module sdtc_top_properties import sdtc_pkg::*; (
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// outputs under watch
	input wire logic              gamma_on_o,
	input wire logic [4:0]        feature_en_o,
	input wire logic [1:0]        sense_en_o,
	input wire logic              mem_req_o,
	input wire logic              mem_gnt_i
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       wr, rd, ga_w, bad_w;
	logic [4:0] fe_w;
	logic [1:0] se_w;
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	assign fe_w = pwdata[24:20];
	assign se_w = {pwdata[26], pwdata[24]};
	assign ga_w = pwdata[3] && (pwdata[1:0] == 2'h1 || pwdata[1:0] == 2'h2);
	assign bad_w = paddr < OFF_CTRL || paddr > OFF_SCALE || paddr[1:0] != 0;
	feature_copy_a: assert property (wr && paddr == OFF_CTRL |=>
		feature_en_o == $past(fe_w)) else $error("feature enables wrong");
	gamma_gate_a: assert property (wr && paddr == OFF_CTRL |=>
		gamma_on_o == $past(ga_w)) else $error("gamma flag wrong");
	sense_enable_a: assert property (wr && paddr == OFF_MON |=>
		sense_en_o == $past(se_w)) else $error("sense enables wrong");
	base_low_a: assert property (rd && paddr == OFF_FB |->
		prdata[3:0] == 4'h0) else $error("base low bits set");
	stride_zero_a: assert property (rd && paddr == OFF_STR |->
		prdata[19:16] == 4'h0 && prdata[3:0] == 4'h0)
		else $error("stride zero bits set");
	line_field_a: assert property (rd && paddr == OFF_LINE |->
		prdata[31:11] == 21'h0) else $error("line upper bits set");
	bad_access_a: assert property (psel && penable |->
		pslverr == bad_w) else $error("slave error wrong");
	req_drop_a: assert property (mem_req_o && mem_gnt_i |=>
		!mem_req_o) else $error("request held after grant");
	ready_up_a: assert property ($past(presetn) |-> pready)
		else $error("ready low after reset");
endmodule
bind sdtc_top sdtc_top_properties i_sdtc_top_properties (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .gamma_on_o(gamma_on_o),
	.feature_en_o(feature_en_o), .sense_en_o(sense_en_o),
	.mem_req_o(mem_req_o), .mem_gnt_i(mem_gnt_i));

// File: test/sdtc_top_tb.sv
// self-checking bench of the secondary display timing block
`timescale 1ns/100ps
module sdtc_top_tb;
	import sdtc_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic         pix, hsync_o, vsync_o, blank_o, gam, gnt, rv, req, ext;
	logic         serr, h0;
	logic [19:0]  paddr;
	logic [31:0]  pwdata, prdata, rdat, d;
	logic [23:0]  rgb_o, panel;
	logic [17:0]  vga;
	logic [25:0]  maddr;
	logic [127:0] mdata;
	logic [1:0]   sen, sense;
	int           miscompares, samples_checked, c, w, p;
	logic [31:0]  wm [11] = '{WM_CTRL, WM_FB, WM_STR, WM_HTOT, WM_HSYNC,
		WM_VTOT, WM_VSYNC, WM_SIG, 32'h0000_0000, WM_MON, WM_SCALE};
	logic [19:0]  bad [2] = '{20'h8_022C, 20'h8_0201};
	sdtc_top i_sdtc_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pix_clk_i(pix),
		.hsync_o(hsync_o), .vsync_o(vsync_o), .crt_clk_o(),
		.blank_o(blank_o), .rgb_o(rgb_o), .gamma_on_o(gam),
		.feature_en_o(), .scale_o(), .panel_rgb_i(panel),
		.vga_rgb_i(vga), .mem_req_o(req), .mem_addr_o(maddr),
		.mem_ext_o(ext), .mem_gnt_i(gnt), .mem_rvalid_i(rv),
		.mem_rdata_i(mdata), .sense_en_o(sen), .sense_i(sense));
	sdtc_mem_model i_sdtc_mem_model (.pclk(pclk), .presetn(presetn),
		.req(req), .addr(maddr), .gnt(gnt), .rvalid(rv), .rdata(mdata));
	always #2 pclk = ~pclk;
	always #16 pix = ~pix;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [19:0] a,
		input logic [31:0] dv);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dv;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) begin
			miscompares++;
			stop_test();
		end
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [19:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk("prdata", e, rdat);
	endtask
	function automatic logic sg(input int s);
		return s == 0 ? hsync_o : (s == 1 ? vsync_o : blank_o);
	endfunction
	// wait while a line sits at one level, counting cycles
	task automatic hold(input int s, input logic lv, output int n);
		n = 0;
		while (sg(s) === lv) begin
			@(posedge pclk);
			n++;
			if (n > 9000) begin
				miscompares++;
				stop_test();
			end
		end
	endtask
	task automatic meas(input int s, input logic lv);
		hold(s, lv, c);
		hold(s, !lv, c);
		hold(s, lv, w);
		hold(s, !lv, c);
		p = w + c;
	endtask
	initial begin
		pclk = 0;
		pix = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
		sense = 2'b00;
		miscompares = 0;
		samples_checked = 0;
		void'($urandom(32'h9d3c_0ec9));
		panel = $urandom;
		vga = $urandom;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < NREG; i++)
			rdc(OFF_CTRL + 20'(4 * i), REG_RST);
		for (int k = 0; k < 22; k++) begin
			d = $urandom & 32'hFFFF_FEFF;
			if (k % NREG == IDX_SIG)
				d = d & 32'h0000_0007;
			apb(1'b1, OFF_CTRL + 20'(4 * (k % NREG)), d);
			d = (d & wm[k % NREG]) | {k % NREG == IDX_FB, 31'h0};
			rdc(OFF_CTRL + 20'(4 * (k % NREG)), d);
		end
		foreach (bad[j]) begin
			apb(1'b1, bad[j], 32'hFFFF_FFFF);
			chk("slverr", 1, serr);
			rdc(bad[j], 32'h0000_0000);
		end
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, OFF_CTRL, 32'h0000_0008 | f);
			@(posedge pclk);
			chk("gamma", f == 1 || f == 2, gam);
		end
		apb(1'b1, OFF_HTOT, 32'h0013_0009);
		apb(1'b1, OFF_HSYNC, 32'h0003_000B);
		apb(1'b1, OFF_VTOT, 32'h0005_0002);
		apb(1'b1, OFF_VSYNC, 32'h0001_0003);
		apb(1'b1, OFF_MON, 32'h0000_0000);
		apb(1'b1, OFF_CTRL, 32'h0000_0100);
		// counts at 8 pclk per pixel
		meas(0, 1'b1);
		chk("lsync width", 3 * 8, w);
		chk("lsync period", 20 * 8, p);
		meas(1, 1'b1);
		chk("fsync width", 1 * 160, w);
		chk("fsync period", 6 * 160, p);
		hold(1, 1'b0, c);
		apb(1'b0, OFF_CTRL, 32'h0000_0000);
		chk("fsync bit", 1, rdat[CTRL_FSTAT]);
		rdc(OFF_LINE, 32'h0000_0004);
		apb(1'b1, OFF_CTRL, 32'h0000_3100);
		meas(0, 1'b0);
		chk("lsync low", 3 * 8, w);
		meas(1, 1'b0);
		chk("fsync low", 160, w);
		apb(1'b1, OFF_CTRL, 32'h0000_0500);
		repeat (12) @(posedge pclk);
		c = 0;
		repeat (400) begin
			@(posedge pclk);
			c += (blank_o !== 1'b1);
		end
		chk("blank", 0, c);
		apb(1'b1, OFF_CTRL, 32'h0000_0100);
		hold(2, 1'b1, c);
		repeat (2) @(posedge pclk);
		chk("panel", panel, rgb_o);
		apb(1'b1, OFF_CTRL, 32'h0004_0100);
		hold(2, 1'b0, c);
		hold(2, 1'b1, c);
		repeat (2) @(posedge pclk);
		d = {vga[17:12], 2'b00, vga[11:6], 2'b00, vga[5:0], 2'b00};
		chk("vga", d, rgb_o);
		apb(1'b1, OFF_CTRL, 32'h0404_0100);
		hold(2, 1'b0, c);
		hold(2, 1'b1, c);
		repeat (2) @(posedge pclk);
		d = {2'b00, vga[17:12], 2'b00, vga[11:6], 2'b00, vga[5:0]};
		chk("vga raw", d, rgb_o);
		// test color and presence per channel
		sense <= 2'b11;
		for (int ch = 0; ch < 2; ch++) begin
			d = (32'h1 << (24 + 2 * ch)) | ($urandom & 32'h00FF_FFFF);
			apb(1'b1, OFF_MON, d);
			repeat (20) @(posedge pclk);
			chk("test rgb", d[23:0], rgb_o);
			chk("sense en", 2'h1 << ch, sen);
			rdc(OFF_MON, d | (32'h1 << (25 + 2 * ch)));
		end
		apb(1'b1, OFF_SIG, 32'h0000_0008);
		repeat (1000) @(posedge pclk);
		apb(1'b1, OFF_SIG, 32'h0000_000C);
		rdc(OFF_SIG, 32'h0000_000C);
		apb(1'b1, OFF_MON, 32'h0000_0000);
		apb(1'b1, OFF_CTRL, 32'h0000_0000);
		repeat (20) @(posedge pclk);
		h0 = hsync_o;
		c = 0;
		repeat (400) begin
			@(posedge pclk);
			c += (hsync_o !== h0);
		end
		chk("frozen", 0, c);
		// plane waits for frame sync, flip pending
		apb(1'b1, OFF_FB, 32'h0800_1000);
		apb(1'b1, OFF_STR, 32'h0020_0040);
		apb(1'b1, OFF_CTRL, 32'h0008_0100);
		hold(1, 1'b0, c);
		hold(1, 1'b1, c);
		apb(1'b1, OFF_CTRL, 32'h0008_0104 | ($urandom & 32'h0003_0000));
		apb(1'b1, OFF_FB, 32'h0800_1000);
		rdc(OFF_FB, 32'h8800_1000);
		c = 0;
		w = 0;
		while (vsync_o !== 1'b1 && w < 2000) begin
			@(posedge pclk);
			c += (req === 1'b1);
			w++;
		end
		chk("early req", 0, c);
		chk("fsync seen", 1, vsync_o);
		rdc(OFF_FB, 32'h0800_1000);
		w = 0;
		while (req !== 1'b1 && w < 4000) begin
			@(posedge pclk);
			w++;
		end
		chk("req", 1, req);
		chk("ext", 1, ext);
		chk("addr", 0, (maddr - 26'h000_1000) % 64);
		stop_test();
	end
endmodule
